//--- verilog/gdio_consts.vh
// Purpose: constants for the general digital I/O port
// Assumes: 8-bit port, plain register port with one-cycle read latency
// Notes:   offsets are word indices on the local register port
`ifndef GDIO_CONSTS_VH
`define GDIO_CONSTS_VH
`define GDIO_WIDTH          8
`define GDIO_ADDR_W         3
`define GDIO_OFF_PIN_INPUT  3'h0
`define GDIO_OFF_DIRECTION  3'h1
`define GDIO_OFF_OUTPUT     3'h2
`define GDIO_OFF_CONTROL    3'h3
`define GDIO_OFF_BITOP      3'h4
`define GDIO_CTRL_PUD_BIT   4
`define GDIO_BITOP_SET_BIT  3
`define GDIO_BITOP_SEL_BIT  4
`define GDIO_RST_DIRECTION  8'h00
`define GDIO_RST_OUTPUT     8'h00
`define GDIO_RST_CONTROL    8'h00
`endif

//--- verilog/gdio_sync.v
// Purpose: input synchronizer, falling-edge capture then rising-edge register
// Assumes: clk is the I/O clock
// Notes:   the negedge stage plays the part of the transparent-high latch
`timescale 1ns/1ps
`include "gdio_consts.vh"
module gdio_sync
(
  // Clock and reset
  input  wire                   clk,
  input  wire                   sys_rst,
  // Pin levels in, synchronized levels out
  input  wire [`GDIO_WIDTH-1:0] pinLevel,
  output reg  [`GDIO_WIDTH-1:0] pinSync
);

  reg [`GDIO_WIDTH-1:0] latch_r;

  // Latch-equivalent: sampled as the clock falls
  always @(negedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      latch_r <= {`GDIO_WIDTH{1'b0}};
    else
      latch_r <= pinLevel;
  end

  // Only the next rising-edge stage reads the first stage
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      pinSync <= {`GDIO_WIDTH{1'b0}};
    else
      pinSync <= latch_r;
  end

endmodule

//--- verilog/gdio_pad.v
// Purpose: per-pin driver and pull-up decode
// Assumes: dir/out bits come from flip-flops
// Notes:   reset forces all outputs off with no clock needed
`timescale 1ns/1ps
`include "gdio_consts.vh"
module gdio_pad
(
  // Controls
  input  wire                   sys_rst,
  input  wire                   pullupDisable,
  input  wire [`GDIO_WIDTH-1:0] dirBits,
  input  wire [`GDIO_WIDTH-1:0] outBits,
  input  wire [`GDIO_WIDTH-1:0] altOwn,
  // Pad controls
  output wire [`GDIO_WIDTH-1:0] padOut,
  output wire [`GDIO_WIDTH-1:0] padOe,
  output wire [`GDIO_WIDTH-1:0] padPullup
);

  genvar n;
  generate
    for (n = 0; n < `GDIO_WIDTH; n = n + 1)
    begin : g_pin
      // Pins owned by a peripheral are left alone; others are unaffected
      assign padOe[n]     = ~sys_rst & ~altOwn[n] & dirBits[n];
      assign padOut[n]    = outBits[n] & dirBits[n];
      assign padPullup[n] = ~sys_rst & ~altOwn[n] & ~dirBits[n] & outBits[n]
                            & ~pullupDisable;
    end
  endgenerate

endmodule

//--- verilog/gdio_port.v
// Purpose: general digital I/O port, registers, toggle and bit ops
// Assumes: register port, read data one cycle after the read strobe
// Notes:   pin reads go through the two-stage synchronizer
`timescale 1ns/1ps
`include "gdio_consts.vh"
module gdio_port
(
  // Clock and reset
  input  wire                    clk,
  input  wire                    sys_rst,
  // Register port
  input  wire [`GDIO_ADDR_W-1:0] regAddr,
  input  wire [7:0]              regWdata,
  input  wire                    regWr,
  input  wire                    regRd,
  output reg  [7:0]              regRdata,
  // Sleep and alternate function
  input  wire                    sleepClamp,
  input  wire [`GDIO_WIDTH-1:0]  extIntEnable,
  input  wire [`GDIO_WIDTH-1:0]  altOwn,
  // Pins
  input  wire [`GDIO_WIDTH-1:0]  pinIn,
  output wire [`GDIO_WIDTH-1:0]  pinOut,
  output wire [`GDIO_WIDTH-1:0]  pinOe,
  output wire [`GDIO_WIDTH-1:0]  pinPullup
);

  reg  [`GDIO_WIDTH-1:0] direction_r;
  reg  [`GDIO_WIDTH-1:0] direction_nxt;
  reg  [`GDIO_WIDTH-1:0] output_r;
  reg  [`GDIO_WIDTH-1:0] output_nxt;
  reg  [7:0]             control_r;
  reg  [7:0]             control_nxt;
  reg  [7:0]             rdata_nxt;
  wire [`GDIO_WIDTH-1:0] pinSync;
  wire [`GDIO_WIDTH-1:0] padLevel;
  wire [`GDIO_WIDTH-1:0] bitMask;
  wire                   pullupDisable;

  assign pullupDisable = control_r[`GDIO_CTRL_PUD_BIT];
  assign bitMask = {{(`GDIO_WIDTH-1){1'b0}}, 1'b1} << regWdata[2:0];

  // Driven level loops back so the pin input sees outputs too
  assign padLevel = (pinIn | (pinOe & pinOut)) & ~(pinOe & ~pinOut);
  // Clamp during deep sleep to stop floating-input current
  wire [`GDIO_WIDTH-1:0] clampedLevel = padLevel & ~(sleepClamp ? ~extIntEnable
                                        : {`GDIO_WIDTH{1'b0}});

  gdio_sync u_sync
  (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .pinLevel (clampedLevel),
    .pinSync  (pinSync)
  );

  gdio_pad u_pad
  (
    .sys_rst       (sys_rst),
    .pullupDisable (pullupDisable),
    .dirBits       (direction_r),
    .outBits       (output_r),
    .altOwn        (altOwn),
    .padOut        (pinOut),
    .padOe         (pinOe),
    .padPullup     (pinPullup)
  );

  always @*
  begin
    direction_nxt = direction_r;
    output_nxt    = output_r;
    control_nxt   = control_r;
    if (regWr)
    begin
      case (regAddr)
        `GDIO_OFF_DIRECTION: direction_nxt = regWdata;
        `GDIO_OFF_OUTPUT:    output_nxt    = regWdata;
        `GDIO_OFF_PIN_INPUT: output_nxt    = output_r ^ regWdata;
        `GDIO_OFF_CONTROL:   control_nxt   = regWdata & 8'h10;
        `GDIO_OFF_BITOP:
        begin
          // Bits 2:0 pin, bit 3 set/clear, bit 4 selects output else direction
          if (regWdata[`GDIO_BITOP_SEL_BIT])
            output_nxt = regWdata[`GDIO_BITOP_SET_BIT] ? (output_r | bitMask)
                                                       : (output_r & ~bitMask);
          else
            direction_nxt = regWdata[`GDIO_BITOP_SET_BIT] ? (direction_r | bitMask)
                                                          : (direction_r & ~bitMask);
        end
        default: ;
      endcase
    end
  end

  always @*
  begin
    rdata_nxt = 8'h00;
    case (regAddr)
      `GDIO_OFF_PIN_INPUT: rdata_nxt = pinSync;
      `GDIO_OFF_DIRECTION: rdata_nxt = direction_r;
      `GDIO_OFF_OUTPUT:    rdata_nxt = output_r;
      `GDIO_OFF_CONTROL:   rdata_nxt = control_r;
      default:             rdata_nxt = 8'h00;
    endcase
  end

  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      direction_r <= `GDIO_RST_DIRECTION;
      output_r    <= `GDIO_RST_OUTPUT;
      control_r   <= `GDIO_RST_CONTROL;
      regRdata    <= 8'h00;
    end
    else
    begin
      direction_r <= direction_nxt;
      output_r    <= output_nxt;
      control_r   <= control_nxt;
      regRdata    <= regRd ? rdata_nxt : 8'h00;
    end
  end

endmodule

//--- verif/gdio_port_monitor.sv
// Purpose: port checker
// Assumes: bound into gdio_port
// Notes: pin outputs are combinational
`timescale 1ns/1ps
module gdio_port_monitor (
  // Every top port
  input wire       clk, sys_rst, regWr, regRd, sleepClamp,
  input wire [2:0] regAddr,
  input wire [7:0] regWdata, regRdata, extIntEnable, altOwn, pinIn, pinOut, pinOe, pinPullup
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  chk_rst_hiz: assert property (disable iff (1'b0) sys_rst |-> !(pinOe|pinPullup))
    else $error("live in reset");
  chk_pu_excl: assert property (!(pinPullup&pinOe)) else $error("pull-up on driver");
  chk_dir_wr: assert property (regWr&&regAddr==3'h1 |=> pinOe==($past(regWdata)&~altOwn))
    else $error("driver enable");
  chk_out_wr: assert property (regWr&&regAddr==3'h2 |=> !((pinOut^$past(regWdata))&pinOe))
    else $error("drive level");
  chk_toggle: assert property (regWr&&regAddr==3'h0 |=>
    !((pinOut^$past(pinOut)^$past(regWdata))&pinOe&$past(pinOe))) else $error("toggle");
  chk_bit_op: assert property (regWr&&regAddr==3'h4 |=>
    !((pinOe^$past(pinOe))&~(8'h01<<$past(regWdata[2:0])))) else $error("bit op");
  chk_pud_off: assert property (regWr&&regAddr==3'h3&&regWdata[4] |=> !pinPullup)
    else $error("pull-up kept");
  chk_pin_read: assert property (regRd&&regAddr==3'h0&&$stable(pinIn)&&!pinOe
    &&!$past(pinOe)&&!sleepClamp |=> regRdata==$past(pinIn)) else $error("pin read");
endmodule
bind gdio_port gdio_port_monitor u_mon (.clk(clk), .sys_rst(sys_rst), .regWr(regWr),
  .regRd(regRd), .sleepClamp(sleepClamp), .regAddr(regAddr), .regWdata(regWdata),
  .regRdata(regRdata), .extIntEnable(extIntEnable), .altOwn(altOwn), .pinIn(pinIn),
  .pinOut(pinOut), .pinOe(pinOe), .pinPullup(pinPullup));

//--- verif/gdio_pin_model.sv
// Purpose: pin-side circuit
// Assumes: bench sets outside drives
// Notes: Undriven pins without pull-up toggle so no stale level hides
`timescale 1ns/1ps
module gdio_pin_model (
  // Pad controls, outside drives, level
  input  wire       clk,
  input  wire [7:0] pinOut, pinOe, pinPullup, extVal, extEn,
  output wire [7:0] pinIn
);
  reg [7:0] flt_r = 8'h00;
  always @(posedge clk) flt_r <= ~flt_r;
  assign pinIn = (pinOe&pinOut)|(~pinOe&((extEn&extVal)|(~extEn&(pinPullup|flt_r))));
endmodule

//--- verif/gdio_port_tb.sv
// Purpose: port bench
// Assumes: 100 ns clock
// Notes: all pins driven outside for the first read, then pins 6 and 7
`timescale 1ns/1ps
module gdio_port_tb;
  reg        clk = 1'b0, sys_rst = 1'b1, regWr = 1'b0, regRd = 1'b0;
  reg  [2:0] regAddr = 3'h0;
  reg  [7:0] regWdata = 8'h00, extVal = 8'h9a, extEn = 8'hff;
  reg        sleepClamp = 1'b0;
  reg  [7:0] extIntEnable = 8'h00, altOwn = 8'h00;
  wire [7:0] regRdata, pinIn, pinOut, pinOe, pinPullup;
  int        nFail = 0, numChecks = 0;
  always #50 clk = ~clk;
  gdio_port DUT (.clk(clk), .sys_rst(sys_rst), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .sleepClamp(sleepClamp),
    .extIntEnable(extIntEnable), .altOwn(altOwn), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe),
    .pinPullup(pinPullup));
  gdio_pin_model u_pins (.clk(clk), .pinOut(pinOut), .pinOe(pinOe), .pinPullup(pinPullup),
    .extVal(extVal), .extEn(extEn), .pinIn(pinIn));
  task cmp(input [7:0] got, input [7:0] exp);
    numChecks++;
    if (got !== exp)
    begin
      nFail++;
      $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
    end
  endtask
  // Read compares against d; gap cycle keeps strobes single
  task acc(input w, input [2:0] a, input [7:0] d);
    @(posedge clk);
    regWr <= w;
    regRd <= !w;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk);
    {regWr, regRd} <= 2'b00;
    #1 if (!w) cmp(regRdata, d);
  endtask
  task stop_test;
    $display("checks %0d fails %0d", numChecks, nFail);
    if (nFail == 0 && numChecks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk);
    acc(1'b0, 3'h0, 8'h9a);
    @(posedge clk);
    extEn <= 8'hc0;
    acc(1'b1, 3'h1, 8'h0f);
    acc(1'b1, 3'h2, 8'h37);
    cmp(pinOe, 8'h0f);
    cmp(pinPullup, 8'h30);
    cmp(pinOut, 8'h07);
    acc(1'b0, 3'h0, 8'hb7);
    $display("test 1 end");
    acc(1'b1, 3'h3, 8'h10);
    acc(1'b1, 3'h0, 8'h81);
    acc(1'b0, 3'h2, 8'hb6);
    acc(1'b1, 3'h4, 8'h1b);
    acc(1'b1, 3'h4, 8'h01);
    acc(1'b0, 3'h2, 8'hbe);
    acc(1'b0, 3'h1, 8'h0d);
    cmp(pinOe, 8'h0d);
    cmp(pinOut, 8'h0c);
    cmp(pinPullup, 8'h00);
    // Sleep clamps all inputs but the wake pin; pin 0 handed to a peripheral
    @(posedge clk);
    altOwn <= 8'h01;
    extIntEnable <= 8'h80;
    sleepClamp <= 1'b1;
    acc(1'b0, 3'h0, 8'h80);
    cmp(pinOe, 8'h0c);
    acc(1'b1, 3'h3, 8'h00);
    cmp(pinPullup, 8'hb2);
    $display("test 3 end");
    @(posedge clk);
    sleepClamp <= 1'b0;
    altOwn <= 8'h00;
    @(posedge clk);
    sys_rst <= 1'b1;
    #20 cmp(pinOe | pinPullup, 8'h00);
    cmp(pinOut, 8'h00);
    $display("test 2 end");
    stop_test;
  end
endmodule
